/* File: src/wdt_top.sv */
// Watchdog time-out timer: registers, down-counter, time-out routing
// Functional notes
// - Nonzero counter write loads and starts countdown
// - Zero disables; N counts N units
// - Counter read returns live count
// - Mouse/keyboard events reload when enabled
// - Mode bit 3 selects seconds or minutes
// - Mode bit 4 counts thousand times faster
// - Enabled reset-line rising edge causes time-out
// - Mode bit 1 gates low reset pulse
// - Trigger bit forces time-out, self-clears
// - Status bit sets on time-out, write-zero clears
// - Low control bits route time-out interrupt
// - Activation bit gates time-out and LED
`timescale 1ns/1ns
module wdt_top #(
  parameter int SEC_CYC = wdt_pkg::SEC_CYCLES,
  parameter int MS_CYC = wdt_pkg::MS_CYCLES,
  parameter int PULSE_CYC = wdt_pkg::RESET_PULSE_CYCLES,
  parameter int LED_HALF_CYC = wdt_pkg::POWER_LED_PIN_HALF_NS / wdt_pkg::CLK_PERIOD_NS
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic mouseIrqEvt,
  input wire logic kbdIrqEvt,
  input wire logic kbcResetLine,
  output logic watchdogTimeoutOutN,
  output logic keyboardResetPinN,
  output logic [15:0] irqLines,
  output logic systemMgmtInterruptN,
  output logic powerLedPin,
  output logic intrOut
);
  import wdt_pkg::*;
  wdt_tick_if tk ();

  logic [7:0] modeFf, nxtMode, cntFf, nxtCnt, reloadFf, nxtReload;
  logic [7:0] ctrlFf, nxtCtrl, actFf, nxtAct, rdFf, nxtRd;
  logic [1:0] istatFf, nxtIstat, imaskFf, nxtImask;
  logic kbcPrevFf, toFf, nxtTo, intrFf, smiFf, ledFf, nxtLed, nxtSmi, nxtIntr;
  logic [15:0] irqFf, nxtIrq;
  logic [31:0] ledCntFf, nxtLedCnt;
  logic active, wrMode, wrCnt, wrCtrl, wrAct, reloadEvt, expire, timeout, pulseN;

  // One-hot steering of the time-out onto the selected line
  function automatic logic [15:0] route(input logic [3:0] sel, input logic on);
    route = on ? (16'h0001 << sel) : 16'h0000;
  endfunction

  assign active = actFf[ACT_EN_BIT];
  assign wrMode = regWr && regAddr == MODE_OFS;
  assign wrCnt = regWr && regAddr == CNT_OFS;
  assign wrCtrl = regWr && regAddr == CTRL_OFS;
  assign wrAct = regWr && regAddr == ACT_OFS;
  assign tk.fast = modeFf[MODE_FAST_BIT];
  assign tk.minute = modeFf[MODE_MIN_BIT];
  assign tk.run = cntFf != 8'h00 && !wrCnt && !reloadEvt;
  assign reloadEvt = (mouseIrqEvt && ctrlFf[CTRL_MOUSE_BIT]
    || kbdIrqEvt && ctrlFf[CTRL_KBD_BIT]) && reloadFf != 8'h00;
  assign expire = tk.tick && cntFf == 8'h01 && !wrCnt && !reloadEvt;

  // Time-out sources: expiry, software trigger, reset-line edge
  always_comb
  begin
    timeout = expire;
    if (wrCtrl && regWdata[CTRL_TRIG_BIT])
      timeout = 1'b1;
    if (modeFf[MODE_KBCEN_BIT] && kbcResetLine && !kbcPrevFf)
      timeout = 1'b1;
    timeout = timeout && active;
  end

  // Register and counter next state
  always_comb
  begin
    nxtMode = modeFf;
    nxtCnt = cntFf;
    nxtReload = reloadFf;
    nxtCtrl = ctrlFf;
    nxtAct = actFf;
    nxtImask = imaskFf;
    nxtIstat = istatFf;
    if (wrMode)
      nxtMode = regWdata & MODE_WMASK;
    if (wrAct)
      nxtAct = regWdata & 8'h01;
    if (regWr && regAddr == IMASK_OFS)
      nxtImask = regWdata[1:0];
    if (wrCnt)
    begin
      nxtCnt = regWdata;
      if (regWdata != 8'h00)
        nxtReload = regWdata;
    end
    else if (reloadEvt)
      nxtCnt = reloadFf;
    else if (tk.tick && cntFf != 8'h00)
      nxtCnt = cntFf - 8'h01;
    if (wrCtrl)
    begin
      nxtCtrl = (regWdata & CTRL_WMASK) | (ctrlFf & 8'h10);
      if (!regWdata[CTRL_STAT_BIT])
        nxtCtrl[CTRL_STAT_BIT] = 1'b0;
    end
    if (timeout)
      nxtCtrl[CTRL_STAT_BIT] = 1'b1;
    if (regRd && regAddr == ISTAT_OFS)
      nxtIstat = 2'b00;
    if (timeout)
      nxtIstat[0] = 1'b1;
    if (reloadEvt)
      nxtIstat[1] = 1'b1;
  end

  // Read mux; trigger bit always reads zero, self-clearing
  always_comb
  begin
    nxtRd = 8'h00;
    if (regRd)
    begin
      unique case (regAddr)
        MODE_OFS: nxtRd = modeFf;
        CNT_OFS: nxtRd = cntFf;
        CTRL_OFS: nxtRd = ctrlFf & ~8'h20;
        ACT_OFS: nxtRd = actFf;
        ISTAT_OFS: nxtRd = {6'h00, istatFf};
        IMASK_OFS: nxtRd = {6'h00, imaskFf};
        default: nxtRd = 8'h00;
      endcase
    end
  end

  // Output levels: routed interrupt tracks the sticky status
  always_comb
  begin
    nxtTo = !(ctrlFf[CTRL_STAT_BIT] && active);
    nxtIrq = route(ctrlFf[3:0], ctrlFf[CTRL_STAT_BIT] && active);
    nxtSmi = !(ctrlFf[3:0] == IRQ_SMI_SEL && ctrlFf[CTRL_STAT_BIT] && active);
    nxtIntr = |(nxtIstat & nxtImask);
    nxtLedCnt = ledCntFf + 32'h1;
    nxtLed = ledFf;
    if (!active)
    begin
      nxtLedCnt = '0;
      nxtLed = 1'b0;
    end
    else if (ledCntFf >= 32'(LED_HALF_CYC - 1))
    begin
      nxtLedCnt = '0;
      nxtLed = !ledFf;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      modeFf <= MODE_RST;
      cntFf <= CNT_RST;
      reloadFf <= CNT_RST;
      ctrlFf <= CTRL_RST;
      actFf <= ACT_RST;
      istatFf <= 2'b00;
      imaskFf <= 2'b00;
      rdFf <= 8'h00;
      kbcPrevFf <= 1'b0;
      toFf <= 1'b1;
      irqFf <= 16'h0000;
      smiFf <= 1'b1;
      intrFf <= 1'b0;
      ledFf <= 1'b0;
      ledCntFf <= '0;
    end
    else
    begin
      modeFf <= nxtMode;
      cntFf <= nxtCnt;
      reloadFf <= nxtReload;
      ctrlFf <= nxtCtrl;
      actFf <= nxtAct;
      istatFf <= nxtIstat;
      imaskFf <= nxtImask;
      rdFf <= nxtRd;
      kbcPrevFf <= kbcResetLine;
      toFf <= nxtTo;
      irqFf <= nxtIrq;
      smiFf <= nxtSmi;
      intrFf <= nxtIntr;
      ledFf <= nxtLed;
      ledCntFf <= nxtLedCnt;
    end
  end

  wdt_prescaler #(.SEC_CYC(SEC_CYC), .MS_CYC(MS_CYC)) uPre (
    .mclk(mclk),
    .rst_n(rst_n),
    .tk(tk)
  );

  // Pulse stretcher is registered, so the pin comes from a flip-flop
  wdt_pulse #(.LEN(PULSE_CYC)) uPulse (
    .mclk(mclk),
    .rst_n(rst_n),
    .fire(timeout && modeFf[MODE_PULSE_BIT]),
    .pulseN(pulseN)
  );

  assign regRdata = rdFf;
  assign watchdogTimeoutOutN = toFf;
  assign keyboardResetPinN = pulseN;
  assign irqLines = irqFf;
  assign systemMgmtInterruptN = smiFf;
  assign powerLedPin = ledFf;
  assign intrOut = intrFf;

  // Counter takes the written value
  AST_LOAD: assert property (@(posedge mclk) disable iff (!rst_n)
    wrCnt && regWdata != 8'h00 |=> cntFf == $past(regWdata))
    else $error("counter not loaded");

  // Zero count never moves on its own, so no expiry time-out can follow
  AST_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
    cntFf == 8'h00 && !wrCnt && !reloadEvt |=> cntFf == 8'h00)
    else $error("zero count moved");

  // Read path shows the live count
  AST_READ: assert property (@(posedge mclk) disable iff (!rst_n)
    regRd && regAddr == CNT_OFS |=> regRdata == $past(cntFf))
    else $error("counter read mismatch");

  // Enabled event restores the saved value
  AST_RELOAD: assert property (@(posedge mclk) disable iff (!rst_n)
    reloadEvt && !wrCnt |=> cntFf == $past(reloadFf))
    else $error("reload failed");

  // Software trigger reaches status and pin
  AST_TRIG: assert property (@(posedge mclk) disable iff (!rst_n)
    wrCtrl && regWdata[CTRL_TRIG_BIT] && active |=> ctrlFf[CTRL_STAT_BIT] ##1 !toFf)
    else $error("trigger lost");

  // Trigger bit never reads back as one
  AST_TRIGRD: assert property (@(posedge mclk) disable iff (!rst_n)
    regRd && regAddr == CTRL_OFS |=> !regRdata[CTRL_TRIG_BIT])
    else $error("trigger bit read high");

  // Status holds until software clears it
  AST_STICKY: assert property (@(posedge mclk) disable iff (!rst_n)
    ctrlFf[CTRL_STAT_BIT] && !wrCtrl |=> ctrlFf[CTRL_STAT_BIT])
    else $error("status dropped");

  // Output pin idle whenever status is clear
  AST_TOPIN: assert property (@(posedge mclk) disable iff (!rst_n)
    !ctrlFf[CTRL_STAT_BIT] |=> watchdogTimeoutOutN)
    else $error("time-out pin low without status");

  // Disabled pulse must never reach the pin
  AST_PULSE: assert property (@(posedge mclk) disable iff (!rst_n)
    timeout && !modeFf[MODE_PULSE_BIT] && keyboardResetPinN |=> keyboardResetPinN)
    else $error("pulse while disabled");

  // Enabled pulse starts right after the time-out
  AST_PINLOW: assert property (@(posedge mclk) disable iff (!rst_n)
    timeout && modeFf[MODE_PULSE_BIT] |=> !keyboardResetPinN)
    else $error("reset pulse missing");

  // Inactive unit raises no new status
  AST_GATE: assert property (@(posedge mclk) disable iff (!rst_n)
    !active |=> !ctrlFf[CTRL_STAT_BIT] || $past(ctrlFf[CTRL_STAT_BIT]))
    else $error("time-out while inactive");

  // Inactive unit keeps the lamp dark
  AST_LEDOFF: assert property (@(posedge mclk) disable iff (!rst_n)
    !active |=> !powerLedPin)
    else $error("lamp lit while inactive");

  // Enabled reset-line edge behaves like a time-out
  AST_KBC: assert property (@(posedge mclk) disable iff (!rst_n)
    active && modeFf[MODE_KBCEN_BIT] && $rose(kbcResetLine) |=> ctrlFf[CTRL_STAT_BIT])
    else $error("reset-line edge ignored");

  // Selected line carries the time-out
  AST_ROUTE: assert property (@(posedge mclk) disable iff (!rst_n)
    ctrlFf[CTRL_STAT_BIT] && active |=> irqLines == (16'h0001 << $past(ctrlFf[3:0])))
    else $error("time-out on wrong line");

  // Management interrupt follows selection code two
  AST_SMI: assert property (@(posedge mclk) disable iff (!rst_n)
    ctrlFf[3:0] == IRQ_SMI_SEL && ctrlFf[CTRL_STAT_BIT] && active
    |=> !systemMgmtInterruptN)
    else $error("management interrupt missing");

  // One step down per tick
  AST_STEP: assert property (@(posedge mclk) disable iff (!rst_n)
    tk.tick && cntFf != 8'h00 && !wrCnt && !reloadEvt |=> cntFf == $past(cntFf) - 8'h01)
    else $error("count step wrong");

  // Stray steps between ticks would shorten the time-out
  AST_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    !tk.tick && !wrCnt && !reloadEvt |=> $stable(cntFf))
    else $error("count moved without tick");

  // Last step to zero raises the time-out
  AST_EXPIRE: assert property (@(posedge mclk) disable iff (!rst_n)
    tk.tick && cntFf == 8'h01 && !wrCnt && !reloadEvt && active
    |=> ctrlFf[CTRL_STAT_BIT] && cntFf == 8'h00)
    else $error("expiry missed");

  // Unused mode bits read back as zero
  AST_RSVD: assert property (@(posedge mclk) disable iff (!rst_n)
    regRd && regAddr == MODE_OFS |=> (regRdata & ~MODE_WMASK) == 8'h00)
    else $error("reserved mode bits set");
endmodule

/* File: src/wdt_pkg.sv */
// Package: register map, field positions, reset values and timing for the watchdog
package wdt_pkg;
  localparam logic [7:0] MODE_OFS = 8'hF5;
  localparam logic [7:0] CNT_OFS = 8'hF6;
  localparam logic [7:0] CTRL_OFS = 8'hF7;
  localparam logic [7:0] ACT_OFS = 8'h30;
  localparam logic [7:0] ISTAT_OFS = 8'hF8;
  localparam logic [7:0] IMASK_OFS = 8'hF9;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] ACT_RST = 8'h00;
  localparam logic [7:0] MODE_WMASK = 8'h1E;
  localparam logic [7:0] CTRL_WMASK = 8'hCF;
  localparam int MODE_FAST_BIT = 4;
  localparam int MODE_MIN_BIT = 3;
  localparam int MODE_KBCEN_BIT = 2;
  localparam int MODE_PULSE_BIT = 1;
  localparam int CTRL_MOUSE_BIT = 7;
  localparam int CTRL_KBD_BIT = 6;
  localparam int CTRL_TRIG_BIT = 5;
  localparam int CTRL_STAT_BIT = 4;
  localparam int ACT_EN_BIT = 0;
  localparam logic [3:0] IRQ_SMI_SEL = 4'h2;
  localparam int CLK_HZ = 20000000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int FAST_FACTOR = 1000;
  localparam int SEC_PER_MIN = 60;
  localparam int SEC_CYCLES = CLK_HZ;
  localparam int MS_CYCLES = CLK_HZ / FAST_FACTOR;
  localparam int RESET_PULSE_NS = 1000;
  localparam int RESET_PULSE_CYCLES = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POWER_LED_PIN_HALF_NS = 500000000;
endpackage

/* File: src/wdt_tick_if.sv */
// Interface: tick request and unit selection between core and prescaler
`timescale 1ns/1ns
interface wdt_tick_if;
  logic fast;
  logic minute;
  logic run;
  logic tick;
  modport core (output fast, output minute, output run, input tick);
  modport pre (input fast, input minute, input run, output tick);
endinterface

/* File: src/wdt_prescaler.sv */
// Prescaler: one-cycle tick per selected count unit
`timescale 1ns/1ns
module wdt_prescaler #(
  parameter int SEC_CYC = wdt_pkg::SEC_CYCLES,
  parameter int MS_CYC = wdt_pkg::MS_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  wdt_tick_if.pre tk
);
  import wdt_pkg::*;
  logic [31:0] baseFf, nxtBase;
  logic [5:0] minFf, nxtMin;
  logic tickFf, nxtTick;
  logic [31:0] baseLim;

  // Base divider, then divide by sixty for minute units
  always_comb
  begin
    baseLim = tk.fast ? 32'(MS_CYC - 1) : 32'(SEC_CYC - 1);
    nxtBase = baseFf;
    nxtMin = minFf;
    nxtTick = 1'b0;
    if (!tk.run)
    begin
      nxtBase = '0;
      nxtMin = '0;
    end
    else if (baseFf >= baseLim)
    begin
      nxtBase = '0;
      if (!tk.minute || minFf == 6'(SEC_PER_MIN - 1))
      begin
        nxtMin = '0;
        nxtTick = 1'b1;
      end
      else
        nxtMin = minFf + 6'h01;
    end
    else
      nxtBase = baseFf + 32'h1;
  end

  // Registers only
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      baseFf <= '0;
      minFf <= '0;
      tickFf <= 1'b0;
    end
    else
    begin
      baseFf <= nxtBase;
      minFf <= nxtMin;
      tickFf <= nxtTick;
    end
  end
  assign tk.tick = tickFf;

  // Second unit ticks on each full base period
  AST_SECOND: assert property (@(posedge mclk) disable iff (!rst_n)
    tk.run && !tk.minute && !tk.fast && baseFf == 32'(SEC_CYC - 1) |=> tk.tick)
    else $error("second tick missing");

  // Minute unit waits for the sixtieth base period
  AST_MINUTE: assert property (@(posedge mclk) disable iff (!rst_n)
    tk.run && tk.minute && minFf != 6'(SEC_PER_MIN - 1) |=> !tk.tick)
    else $error("early minute tick");

  // Fast mode ticks on the short period
  AST_FAST: assert property (@(posedge mclk) disable iff (!rst_n)
    tk.run && !tk.minute && tk.fast && baseFf == 32'(MS_CYC - 1) |=> tk.tick)
    else $error("fast tick missing");

  // Normal speed never ticks before a full period
  AST_SLOW: assert property (@(posedge mclk) disable iff (!rst_n)
    tk.run && !tk.fast && baseFf < 32'(SEC_CYC - 1) |=> !tk.tick)
    else $error("early slow tick");
endmodule

/* File: src/wdt_pulse.sv */
// Pulse stretcher: fixed-length active-low pulse on a trigger
`timescale 1ns/1ns
module wdt_pulse #(
  parameter int LEN = wdt_pkg::RESET_PULSE_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic fire,
  output logic pulseN
);
  logic [15:0] cntFf, nxtCnt;
  logic outFf, nxtOut;

  // Retrigger restarts the full length
  always_comb
  begin
    nxtCnt = cntFf;
    if (fire)
      nxtCnt = 16'(LEN);
    else if (cntFf != 16'h0000)
      nxtCnt = cntFf - 16'h0001;
    nxtOut = (nxtCnt == 16'h0000);
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cntFf <= 16'h0000;
      outFf <= 1'b1;
    end
    else
    begin
      cntFf <= nxtCnt;
      outFf <= nxtOut;
    end
  end
  assign pulseN = outFf;
endmodule

/* File: test/tb.sv */
// Testbench: registers, counting, reload, routing and gating of the watchdog
`timescale 1ns/1ns
module tb;
  import wdt_pkg::*;
  logic mclk;
  logic rst_n;
  logic [7:0] regAddr;
  logic [7:0] regWdata;
  logic regWr;
  logic regRd;
  logic [7:0] regRdata;
  logic mouseIrqEvt;
  logic kbdIrqEvt;
  logic kbcResetLine;
  logic watchdogTimeoutOutN;
  logic keyboardResetPinN;
  logic [15:0] irqLines;
  logic systemMgmtInterruptN;
  logic powerLedPin;
  logic intrOut;
  logic [7:0] rdVal;
  int fail_count;
  int num_checks;
  // Short units keep the minute case affordable
  int unitCyc [4] = '{20, 4, 1200, 240};
  logic [7:0] modeTab [4] = '{8'h00, 8'h10, 8'h08, 8'h18};

  wdt_top #(.SEC_CYC(20), .MS_CYC(4), .PULSE_CYC(20), .LED_HALF_CYC(8)) dut_u (
    .mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .mouseIrqEvt(mouseIrqEvt), .kbdIrqEvt(kbdIrqEvt),
    .kbcResetLine(kbcResetLine), .watchdogTimeoutOutN(watchdogTimeoutOutN),
    .keyboardResetPinN(keyboardResetPinN), .irqLines(irqLines),
    .systemMgmtInterruptN(systemMgmtInterruptN), .powerLedPin(powerLedPin),
    .intrOut(intrOut)
  );

  // 20 MHz clock
  initial
  begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end

  // Comparison and bus helpers
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'h1;
    @(posedge mclk);
    regWr <= 1'h0;
  endtask

  // Read data only stands in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge mclk);
    regRd <= 1'h0;
    #1;
    d = regRdata;
  endtask

  task evt(input bit m);
    @(posedge mclk);
    if (m)
      mouseIrqEvt <= 1'h1;
    else
      kbdIrqEvt <= 1'h1;
    @(posedge mclk);
    mouseIrqEvt <= 1'h0;
    kbdIrqEvt <= 1'h0;
  endtask

  // Bounded wait for the time-out output to fall
  task waitTo(input int n);
    int i;
    i = 0;
    while (i < n && watchdogTimeoutOutN !== 1'h0)
    begin
      cyc(1);
      i++;
    end
  endtask

  task t_reset();
    logic [7:0] adr [5];
    int k;
    adr = '{MODE_OFS, CNT_OFS, CTRL_OFS, ACT_OFS, 8'h42};
    for (k = 0; k < 5; k++)
    begin
      rd(adr[k], rdVal);
      chk(rdVal, 8'h00);
    end
    chk({keyboardResetPinN, watchdogTimeoutOutN}, 2'h3);
    chk({irqLines, systemMgmtInterruptN, powerLedPin, intrOut}, 19'h00004);
  endtask

  // Live count, then every unit and speed combination
  task t_count();
    int k;
    wr(ACT_OFS, 8'h01);
    wr(CNT_OFS, 8'h03);
    rd(CNT_OFS, rdVal);
    chk(rdVal, 8'h03);
    cyc(20);
    rd(CNT_OFS, rdVal);
    chk(rdVal, 8'h02);
    for (k = 0; k < 4; k++)
    begin
      wr(MODE_OFS, modeTab[k]);
      wr(CTRL_OFS, 8'h00);
      wr(CNT_OFS, 8'h02);
      cyc(2 * unitCyc[k] - 6);
      chk(watchdogTimeoutOutN, 1'h1);
      waitTo(12);
      chk(watchdogTimeoutOutN, 1'h0);
    end
    wr(MODE_OFS, 8'h10);
    wr(CTRL_OFS, 8'h00);
    wr(CNT_OFS, 8'h05);
    wr(CNT_OFS, 8'h00);
    cyc(60);
    chk(watchdogTimeoutOutN, 1'h1);
  endtask

  // Only the enabled event source reloads
  task t_reload();
    wr(MODE_OFS, 8'h00);
    wr(CTRL_OFS, 8'h40);
    wr(CNT_OFS, 8'h02);
    cyc(25);
    evt(1'b1);
    rd(CNT_OFS, rdVal);
    chk(rdVal, 8'h01);
    evt(1'b0);
    rd(CNT_OFS, rdVal);
    chk(rdVal, 8'h02);
    wr(CTRL_OFS, 8'h80);
    cyc(22);
    evt(1'b1);
    rd(CNT_OFS, rdVal);
    chk(rdVal, 8'h02);
    wr(CNT_OFS, 8'h00);
  endtask

  // Forced time-out, routing, pulse, interrupt and clearing
  task t_route();
    wr(IMASK_OFS, 8'h01);
    rd(ISTAT_OFS, rdVal);
    wr(MODE_OFS, 8'h02);
    wr(CTRL_OFS, 8'h22);
    cyc(3);
    chk({systemMgmtInterruptN, irqLines}, 17'h00004);
    chk(keyboardResetPinN, 1'h0);
    chk(intrOut, 1'h1);
    rd(CTRL_OFS, rdVal);
    chk(rdVal, 8'h12);
    rd(ISTAT_OFS, rdVal);
    chk(rdVal & 8'h01, 8'h01);
    cyc(2);
    chk(intrOut, 1'h0);
    cyc(16);
    chk({keyboardResetPinN, watchdogTimeoutOutN}, 2'h2);
    wr(CTRL_OFS, 8'h05);
    cyc(3);
    chk({watchdogTimeoutOutN, irqLines}, 17'h10000);
    wr(IMASK_OFS, 8'h00);
    wr(MODE_OFS, 8'h00);
    wr(CTRL_OFS, 8'h25);
    cyc(3);
    chk({systemMgmtInterruptN, irqLines}, 17'h10020);
    chk({keyboardResetPinN, intrOut}, 2'h2);
  endtask

  task t_kbc();
    wr(CTRL_OFS, 8'h00);
    @(posedge mclk);
    kbcResetLine <= 1'h1;
    cyc(5);
    chk(watchdogTimeoutOutN, 1'h1);
    @(posedge mclk);
    kbcResetLine <= 1'h0;
    wr(MODE_OFS, 8'h04);
    @(posedge mclk);
    kbcResetLine <= 1'h1;
    waitTo(6);
    chk(watchdogTimeoutOutN, 1'h0);
  endtask

  // Reserved bits, unmapped place, inactive unit
  task t_gate();
    wr(CTRL_OFS, 8'h00);
    wr(ACT_OFS, 8'hFF);
    rd(ACT_OFS, rdVal);
    chk(rdVal, 8'h01);
    // Lamp must change state once per half period while active
    rdVal[0] = powerLedPin;
    cyc(8);
    chk(powerLedPin, !rdVal[0]);
    wr(MODE_OFS, 8'hFF);
    rd(MODE_OFS, rdVal);
    chk(rdVal, 8'h1E);
    wr(8'h42, 8'hFF);
    rd(8'h42, rdVal);
    chk(rdVal, 8'h00);
    wr(MODE_OFS, 8'h00);
    wr(ACT_OFS, 8'h00);
    wr(CTRL_OFS, 8'h20);
    cyc(9);
    chk({watchdogTimeoutOutN, powerLedPin}, 2'h2);
    cyc(9);
    chk({watchdogTimeoutOutN, powerLedPin}, 2'h2);
  endtask

  task complete_run();
    if (fail_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    rst_n = 1'h0;
    regAddr = 8'h00;
    regWdata = 8'h00;
    regWr = 1'h0;
    regRd = 1'h0;
    mouseIrqEvt = 1'h0;
    kbdIrqEvt = 1'h0;
    kbcResetLine = 1'h0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'h1;
    t_reset();
    t_count();
    t_reload();
    t_route();
    t_kbc();
    t_gate();
    complete_run();
  end

  // Run should end well inside 20000 cycles
  initial
  begin
    #1000000;
    fail_count++;
    complete_run();
  end
endmodule
